//--- hw/ctc_core.v
// Compact 16-bit timer/counter core with byte register port
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Operation
// - 16-bit up-counter advances on each tick
// - P compares top byte; A compares all
// - Auto clear on overflow or selected match
// - Run rising clears count; falling freezes it
// - Run bit three enables counting
// - Hold bit seven pauses, keeps value
// - Bits six to four select tick source
// - Run rising restores pin initial level
// - Control A bits two to zero read zero
// - Match low write fills holding buffer only
// - High write copies buffer to low byte
// - High read copies low into buffer
// - Low reads return holding buffer
// - Compare match drives, clears or toggles pin
// - Count read-only; match registers read-write
// - Mode field selects compare, PWM, timer
// - Action field sets pin match reaction
// - Clear select picks A or P/overflow
module ctc_core (
  input wire ref_clk,
  input wire srst,
  input wire clk_en,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire hi_clk_tick,
  input wire sub_clk_tick,
  input wire ext_tick_pin,
  output reg timer_out_pin,
  output wire irq_a_flag,
  output wire irq_p_flag
);
`include "ctc_regs.vh"
  reg [7:0] ctrl_a_r;
  reg [7:0] ctrl_b_r;
  reg [15:0] count_r;
  reg [15:0] match_a_r;
  reg [7:0] match_p_r;
  reg [7:0] hold_buf_r;
  reg [1:0] flags_r;
  reg run_d_r;
  reg pin_lvl_r;
  reg pwm_lvl_r;
  wire tick;
  wire run;
  wire hold;
  wire [1:0] mode;
  wire [1:0] action;
  wire init_lvl;
  wire invert;
  wire swap;
  wire clr_sel;
  wire run_rise;
  wire advance;
  wire match_a;
  wire match_p;
  wire overflow;
  wire period_hit;
  wire duty_hit;
  wire clear_cnt;
  wire [15:0] count_inc;
  wire wr_a;
  wire wr_b;
  wire wr_ma_lo;
  wire wr_ma_hi;
  wire wr_mp;
  wire wr_flags;
  wire rd_cnt_hi;
  wire rd_ma_hi;
  wire [1:0] flag_set;
  reg [7:0] rd_nxt;
  reg pin_nxt;
  reg pwm_act;

  //////////////////////////////////////////////////////////////////////////////
  // Field decode of the control registers
  assign run = ctrl_a_r[`CTC_A_RUN_BIT];
  assign hold = ctrl_a_r[`CTC_A_HOLD_BIT];
  assign mode = ctrl_b_r[`CTC_B_MODE_HI:`CTC_B_MODE_LO];
  assign action = ctrl_b_r[`CTC_B_ACT_HI:`CTC_B_ACT_LO];
  assign init_lvl = ctrl_b_r[`CTC_B_INIT_BIT];
  assign invert = ctrl_b_r[`CTC_B_INV_BIT];
  assign swap = ctrl_b_r[`CTC_B_SWAP_BIT];
  assign clr_sel = ctrl_b_r[`CTC_B_CLRSEL_BIT];

  // Bus strobe decode
  assign wr_a = reg_wr && (reg_addr == `CTC_ADDR_CTRL_A);
  assign wr_b = reg_wr && (reg_addr == `CTC_ADDR_CTRL_B);
  assign wr_ma_lo = reg_wr && (reg_addr == `CTC_ADDR_MA_LO);
  assign wr_ma_hi = reg_wr && (reg_addr == `CTC_ADDR_MA_HI);
  assign wr_mp = reg_wr && (reg_addr == `CTC_ADDR_MP);
  assign wr_flags = reg_wr && (reg_addr == `CTC_ADDR_FLAGS);
  assign rd_cnt_hi = reg_rd && (reg_addr == `CTC_ADDR_CNT_HI);
  assign rd_ma_hi = reg_rd && (reg_addr == `CTC_ADDR_MA_HI);

  //////////////////////////////////////////////////////////////////////////////
  // Tick source and prescaler
  ctc_tick_gen u_tick (
    .ref_clk(ref_clk),
    .srst(srst),
    .clk_en(clk_en),
    .src_sel(ctrl_a_r[`CTC_A_SRC_HI:`CTC_A_SRC_LO]),
    .hi_clk_tick(hi_clk_tick),
    .sub_clk_tick(sub_clk_tick),
    .ext_tick_pin(ext_tick_pin),
    .tick(tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Comparators and clear conditions
  assign run_rise = run && !run_d_r;
  assign advance = run && !hold && tick;
  assign match_a = advance && (count_r == match_a_r);
  // P looks at the value the count is about to take, so P x 256 ticks make one period
  assign count_inc = count_r + 16'h0001;
  assign match_p = advance && (count_inc[15:8] == match_p_r) && (match_p_r != 8'h00);
  assign overflow = advance && (count_r == 16'hffff);
  // In PWM the period register ends the cycle, selected by the swap bit
  assign period_hit = swap ? match_a : (match_p || (overflow && match_p_r == 8'h00));
  assign duty_hit = swap ? match_p : match_a;
  assign clear_cnt = (mode == `CTC_MODE_PWM) ? period_hit :
                     (clr_sel ? match_a : (match_p || overflow));

  //////////////////////////////////////////////////////////////////////////////
  // Previous run level for edge detection
  always @(posedge ref_clk) begin
    if (srst)
      run_d_r <= 1'b0;
    else if (clk_en)
      run_d_r <= run;
  end

  // Counter: cleared on run rise or auto clear, frozen when stopped or held
  always @(posedge ref_clk) begin
    if (srst) begin
      count_r <= 16'h0000;
    end else if (clk_en) begin
      if (run_rise)
        count_r <= 16'h0000;
      else if (clear_cnt)
        count_r <= 16'h0000;
      else if (advance)
        count_r <= count_inc;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control, match and flag registers
  assign flag_set = {match_p, match_a};
  always @(posedge ref_clk) begin
    if (srst) begin
      ctrl_a_r <= `CTC_RST_CTRL;
      ctrl_b_r <= `CTC_RST_CTRL;
      match_a_r <= 16'h0000;
      match_p_r <= 8'h00;
      hold_buf_r <= 8'h00;
      flags_r <= 2'h0;
    end else if (clk_en) begin
      if (wr_a)
        ctrl_a_r <= reg_wdata & `CTC_A_WMASK;
      if (wr_b)
        ctrl_b_r <= reg_wdata;
      if (wr_mp)
        match_p_r <= reg_wdata;
      if (wr_ma_lo)
        hold_buf_r <= reg_wdata;
      else if (rd_cnt_hi)
        hold_buf_r <= count_r[7:0];
      else if (rd_ma_hi)
        hold_buf_r <= match_a_r[7:0];
      if (wr_ma_hi)
        match_a_r <= {reg_wdata, hold_buf_r};
      // Write one clears; a match in the same cycle wins
      flags_r <= (flags_r & ~(wr_flags ? reg_wdata[1:0] : 2'h0)) | flag_set;
    end
  end
  assign irq_a_flag = flags_r[`CTC_FLAG_A_BIT];
  assign irq_p_flag = flags_r[`CTC_FLAG_P_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // Read mux, data stands one cycle after the strobe
  always @* begin
    case (reg_addr)
      `CTC_ADDR_CTRL_A: rd_nxt = ctrl_a_r & `CTC_A_WMASK;
      `CTC_ADDR_CTRL_B: rd_nxt = ctrl_b_r;
      `CTC_ADDR_CNT_LO: rd_nxt = hold_buf_r;
      `CTC_ADDR_CNT_HI: rd_nxt = count_r[15:8];
      `CTC_ADDR_MA_LO: rd_nxt = hold_buf_r;
      `CTC_ADDR_MA_HI: rd_nxt = match_a_r[15:8];
      `CTC_ADDR_MP: rd_nxt = match_p_r;
      `CTC_ADDR_FLAGS: rd_nxt = {6'h00, flags_r};
      default: rd_nxt = 8'h00;
    endcase
  end
  always @(posedge ref_clk) begin
    if (srst)
      reg_rdata <= 8'h00;
    else if (clk_en)
      reg_rdata <= reg_rd ? rd_nxt : 8'h00;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Compare-output pin level
  always @* begin
    pin_nxt = pin_lvl_r;
    if (run_rise)
      pin_nxt = init_lvl;
    else if (match_a) begin
      case (action)
        `CTC_ACT_NONE: pin_nxt = pin_lvl_r;
        `CTC_ACT_LOW: pin_nxt = 1'b0;
        `CTC_ACT_HIGH: pin_nxt = 1'b1;
        `CTC_ACT_TOG: pin_nxt = ~pin_lvl_r;
        default: pin_nxt = pin_lvl_r;
      endcase
    end
  end

  // PWM active phase: set at period start, dropped at duty match
  always @(posedge ref_clk) begin
    if (srst) begin
      pin_lvl_r <= 1'b0;
      pwm_lvl_r <= 1'b0;
    end else if (clk_en) begin
      pin_lvl_r <= pin_nxt;
      if (run_rise || period_hit)
        pwm_lvl_r <= 1'b1;
      else if (duty_hit)
        pwm_lvl_r <= 1'b0;
    end
  end

  // PWM level per action field; init bit sets active level
  always @* begin
    case (action)
      `CTC_PWM_INACTIVE: pwm_act = 1'b0;
      `CTC_PWM_ACTIVE: pwm_act = 1'b1;
      `CTC_PWM_RUN: pwm_act = pwm_lvl_r & run;
      default: pwm_act = 1'b0;
    endcase
  end

  // Output register, inverted on request; timer mode holds low
  always @(posedge ref_clk) begin
    if (srst)
      timer_out_pin <= 1'b0;
    else if (clk_en) begin
      case (mode)
        `CTC_MODE_CMP: timer_out_pin <= pin_nxt ^ invert;
        `CTC_MODE_PWM: timer_out_pin <= (pwm_act ~^ init_lvl) ^ invert;
        default: timer_out_pin <= 1'b0;
      endcase
    end
  end
endmodule // ctc_core

//--- hw/ctc_regs.vh
// Register offsets, field positions, reset values and tick-source codes for the compact timer
`ifndef CTC_REGS_VH
`define CTC_REGS_VH
`define CTC_ADDR_CTRL_A 3'h0
`define CTC_ADDR_CTRL_B 3'h1
`define CTC_ADDR_CNT_LO 3'h2
`define CTC_ADDR_CNT_HI 3'h3
`define CTC_ADDR_MA_LO 3'h4
`define CTC_ADDR_MA_HI 3'h5
`define CTC_ADDR_MP 3'h6
`define CTC_ADDR_FLAGS 3'h7
`define CTC_A_HOLD_BIT 7
`define CTC_A_SRC_HI 6
`define CTC_A_SRC_LO 4
`define CTC_A_RUN_BIT 3
`define CTC_A_WMASK 8'hf8
`define CTC_B_MODE_HI 7
`define CTC_B_MODE_LO 6
`define CTC_B_ACT_HI 5
`define CTC_B_ACT_LO 4
`define CTC_B_INIT_BIT 3
`define CTC_B_INV_BIT 2
`define CTC_B_SWAP_BIT 1
`define CTC_B_CLRSEL_BIT 0
`define CTC_RST_CTRL 8'h00
`define CTC_FLAG_A_BIT 0
`define CTC_FLAG_P_BIT 1
`define CTC_MODE_CMP 2'h0
`define CTC_MODE_PWM 2'h2
`define CTC_MODE_TMR 2'h3
`define CTC_ACT_NONE 2'h0
`define CTC_ACT_LOW 2'h1
`define CTC_ACT_HIGH 2'h2
`define CTC_ACT_TOG 2'h3
`define CTC_PWM_INACTIVE 2'h0
`define CTC_PWM_ACTIVE 2'h1
`define CTC_PWM_RUN 2'h2
`define CTC_SRC_SYS4 3'h0
`define CTC_SRC_SYS 3'h1
`define CTC_SRC_HI16 3'h2
`define CTC_SRC_HI64 3'h3
`define CTC_SRC_SUB0 3'h4
`define CTC_SRC_SUB1 3'h5
`define CTC_SRC_EXTR 3'h6
`define CTC_SRC_EXTF 3'h7
`define CTC_DIV_SYS4 7'h03
`define CTC_DIV_HI16 7'h0f
`define CTC_DIV_HI64 7'h3f
`endif

//--- hw/ctc_tick_gen.v
// Tick source selection and prescaler for the compact timer
`timescale 1ns/1ps
module ctc_tick_gen (
  input wire ref_clk,
  input wire srst,
  input wire clk_en,
  input wire [2:0] src_sel,
  input wire hi_clk_tick,
  input wire sub_clk_tick,
  input wire ext_tick_pin,
  output reg tick
);
`include "ctc_regs.vh"
  reg [6:0] div_r;
  reg [6:0] hdiv_r;
  reg ext_s1_r;
  reg ext_s2_r;
  reg ext_d_r;
  wire ext_rise;
  wire ext_fall;

  //////////////////////////////////////////////////////////////////////////////
  // Two-stage sync of the external tick pin, then edge detect on the second stage
  always @(posedge ref_clk) begin
    if (srst) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_d_r <= 1'b0;
    end else if (clk_en) begin
      ext_s1_r <= ext_tick_pin;
      ext_s2_r <= ext_s1_r;
      ext_d_r <= ext_s2_r;
    end
  end
  assign ext_rise = ext_s2_r & ~ext_d_r;
  assign ext_fall = ~ext_s2_r & ext_d_r;

  // Free-running prescalers for system and high clock ratios
  always @(posedge ref_clk) begin
    if (srst) begin
      div_r <= 7'h00;
      hdiv_r <= 7'h00;
    end else if (clk_en) begin
      div_r <= div_r + 7'h01;
      if (hi_clk_tick)
        hdiv_r <= hdiv_r + 7'h01;
    end
  end

  // Source multiplexer, one-cycle tick pulse
  always @* begin
    case (src_sel)
      `CTC_SRC_SYS4: tick = ((div_r & `CTC_DIV_SYS4) == `CTC_DIV_SYS4);
      `CTC_SRC_SYS: tick = 1'b1;
      `CTC_SRC_HI16: tick = hi_clk_tick && ((hdiv_r & `CTC_DIV_HI16) == `CTC_DIV_HI16);
      `CTC_SRC_HI64: tick = hi_clk_tick && ((hdiv_r & `CTC_DIV_HI64) == `CTC_DIV_HI64);
      `CTC_SRC_SUB0: tick = sub_clk_tick;
      `CTC_SRC_SUB1: tick = sub_clk_tick;
      `CTC_SRC_EXTR: tick = ext_rise;
      `CTC_SRC_EXTF: tick = ext_fall;
      default: tick = 1'b0;
    endcase
  end
endmodule // ctc_tick_gen

//--- sim/ctc_core_asserts.sv
// Checker for the compact timer register port and flags
`timescale 1ns/1ps
module ctc_core_asserts (
  input wire ref_clk,
  input wire srst,
  input wire clk_en,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire timer_out_pin,
  input wire irq_a_flag,
  input wire irq_p_flag
);
  reg [7:0] ca_r, cb_r, mah_r, mp_r, buf_r;
  reg buf_ok_r;
  ////////////////////////////////////////////////////////////////////////////
  // Shadow copies of readable registers; a high read makes the buffer unknown
  always @(posedge ref_clk) begin
    if (srst) begin
      {ca_r, cb_r, mah_r, mp_r, buf_r} <= 40'h0;
      buf_ok_r <= 1'b1;
    end else if (clk_en && reg_wr) begin
      case (reg_addr)
        3'h0: ca_r <= reg_wdata & 8'hf8;
        3'h1: cb_r <= reg_wdata;
        3'h4: begin
          buf_r <= reg_wdata;
          buf_ok_r <= 1'b1;
        end
        3'h5: mah_r <= reg_wdata;
        3'h6: mp_r <= reg_wdata;
        default: ;
      endcase
    end else if (clk_en && reg_rd && (reg_addr == 3'h3 || reg_addr == 3'h5)) begin
      buf_ok_r <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking dflt_ck @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence s_rd(logic [2:0] a);
    clk_en && reg_rd && reg_addr == a;
  endsequence
  a_ctrl_a_back: assert property (s_rd(3'h0) |=> reg_rdata == ca_r)
    else $error("control a read-back differs");
  a_ctrl_low_zero: assert property (s_rd(3'h0) |=> reg_rdata[2:0] == 3'h0)
    else $error("control a low bits not zero");
  a_ctrl_b_back: assert property (s_rd(3'h1) |=> reg_rdata == cb_r)
    else $error("control b read-back differs");
  a_match_hi_back: assert property (s_rd(3'h5) |=> reg_rdata == mah_r)
    else $error("match a high read-back differs");
  a_match_p_back: assert property (s_rd(3'h6) |=> reg_rdata == mp_r)
    else $error("match p read-back differs");
  a_buf_low_read: assert property (clk_en && reg_rd && buf_ok_r &&
    (reg_addr == 3'h2 || reg_addr == 3'h4) |=> reg_rdata == buf_r)
    else $error("low read not from buffer");
  a_rdata_idle: assert property ($past(clk_en) && !$past(reg_rd) && !$past(srst)
    |-> reg_rdata == 8'h00) else $error("read data outside answer cycle");
  a_flag_a_sticky: assert property (!$past(srst) && $fell(irq_a_flag)
    |-> $past(clk_en && reg_wr && reg_addr == 3'h7 && reg_wdata[0]))
    else $error("flag a dropped alone");
  a_flag_p_sticky: assert property (!$past(srst) && $fell(irq_p_flag)
    |-> $past(clk_en && reg_wr && reg_addr == 3'h7 && reg_wdata[1]))
    else $error("flag p dropped alone");
  a_flag_needs_run: assert property ($rose(irq_a_flag) |-> $past(ca_r[3] && !ca_r[7]))
    else $error("flag a set while stopped or held");
  a_pin_tmr_low: assert property (clk_en && cb_r[7:6] == 2'h3 |=> !timer_out_pin)
    else $error("pin not low in timer mode");
endmodule // ctc_core_asserts

//--- sim/ctc_far_end.sv
// Far-side model: high and sub clock enables and the external tick pin
`timescale 1ns/1ps
module ctc_far_end (
  input wire ref_clk,
  input wire srst,
  output reg hi_clk_tick = 1'b0,
  output reg sub_clk_tick = 1'b0,
  output reg ext_tick_pin = 1'b0
);
  reg [2:0] div_r = 3'h0;
  // Pulses every 2nd and 8th cycle; pin flips every 8 cycles
  always @(posedge ref_clk) begin
    div_r <= srst ? 3'h0 : div_r + 3'h1;
    hi_clk_tick <= div_r[0];
    sub_clk_tick <= (div_r == 3'h7);
    if (div_r == 3'h3) begin
      ext_tick_pin <= ~ext_tick_pin;
    end
  end
endmodule // ctc_far_end

//--- sim/ctc_core_tb.sv
// Self-checking bench for the compact timer core
`timescale 1ns/1ps
`include "ctc_regs.vh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, e); end end
module ctc_core_tb;
  reg ref_clk = 1'b0;
  reg srst = 1'b1;
  reg [2:0] reg_addr = 3'h0;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg clk_en = 1'b1;
  wire [7:0] reg_rdata;
  wire hi_t, sub_t, ext_p, timer_out_pin, irq_a_flag, irq_p_flag;
  int bad_count = 0;
  int n_checks = 0;
  int i;
  reg [15:0] v0, v1;
  reg [7:0] d;
  // Clock
  always #25 ref_clk = ~ref_clk;
  ctc_far_end ctc_far_end_inst (.ref_clk(ref_clk), .srst(srst), .hi_clk_tick(hi_t),
    .sub_clk_tick(sub_t), .ext_tick_pin(ext_p));
  ctc_core ctc_core_inst (.ref_clk(ref_clk), .srst(srst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .hi_clk_tick(hi_t), .sub_clk_tick(sub_t),
    .ext_tick_pin(ext_p), .timer_out_pin(timer_out_pin), .irq_a_flag(irq_a_flag),
    .irq_p_flag(irq_p_flag));
  ////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input [2:0] a, input [7:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input [2:0] a, output [7:0] v);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // High byte first, then the buffered low byte
  task automatic rd16(input [2:0] hi, output [15:0] v);
    reg [7:0] h, l;
    rd(hi, h);
    rd(hi - 3'h1, l);
    v = {h, l};
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    cyc(20000);
    bad_count++;
    close_out;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(8);
    srst <= 1'b0;
    rd(`CTC_ADDR_CNT_LO, d);
    `CHK(d, 8'h00)
    wr(`CTC_ADDR_CTRL_A, 8'h77);
    rd(`CTC_ADDR_CTRL_A, d);
    `CHK(d, 8'h70)
    wr(`CTC_ADDR_CTRL_A, 8'h00);
    wr(3'h4, 8'h5a);
    wr(3'h5, 8'hc3);
    wr(3'h4, 8'h11);
    rd16(3'h5, v0);
    `CHK(v0, 16'hc35a)
    wr(3'h1, 8'ha5);
    rd(3'h1, d);
    `CHK(d, 8'ha5)
    wr(3'h1, 8'h01);
    // Every tick source advances and then freezes
    for (i = 0; i < 8; i++) begin
      wr(3'h0, {1'b0, i[2:0], 4'h8});
      cyc(300);
      wr(3'h0, {1'b0, i[2:0], 4'h0});
      rd16(3'h3, v0);
      rd16(3'h3, v1);
      `CHK(v0 !== 16'h0 && v0 === v1, 1'b1)
    end
    wr(3'h2, 8'hff);
    wr(3'h3, 8'hff);
    rd16(3'h3, v1);
    `CHK(v1, v0)
    wr(3'h0, 8'h98);
    cyc(20);
    rd16(3'h3, v0);
    `CHK(v0, 16'h0)
    wr(3'h0, 8'h18);
    // Clock enable low freezes the count for ten cycles
    clk_en <= 1'b0;
    cyc(10);
    clk_en <= 1'b1;
    wr(3'h0, 8'h10);
    rd16(3'h3, v0);
    `CHK(v0, 16'h0002)
    // Match A at 3: init level on start, pin action on match
    wr(3'h4, 8'h03);
    wr(3'h5, 8'h00);
    for (i = 0; i < 2; i++) begin
      wr(3'h1, i ? 8'h21 : 8'h19);
      wr(3'h0, 8'h18);
      cyc(1);
      `CHK(timer_out_pin, i == 0)
      cyc(10);
      `CHK(timer_out_pin, i == 1)
      wr(3'h0, 8'h10);
      cyc(1);
      `CHK(irq_a_flag, 1'b1)
      wr(3'h7, 8'h01);
      cyc(1);
      `CHK(irq_a_flag, 1'b0)
    end
    // Match P at 1: clear after 256 ticks
    wr(3'h1, 8'h00);
    wr(3'h6, 8'h01);
    wr(3'h0, 8'h18);
    cyc(256);
    `CHK(irq_p_flag, 1'b0)
    cyc(1);
    `CHK(irq_p_flag, 1'b1)
    wr(3'h0, 8'h10);
    rd(3'h6, d);
    `CHK(d, 8'h01)
    wr(3'h7, 8'h02);
    cyc(1);
    `CHK(irq_p_flag, 1'b0)
    // PWM active high from run start until the duty match at 3
    wr(3'h1, 8'ha8);
    wr(3'h0, 8'h18);
    cyc(3);
    `CHK(timer_out_pin, 1'b1)
    cyc(10);
    `CHK(timer_out_pin, 1'b0)
    // Forced active level, then timer mode pulls the pin low
    wr(3'h0, 8'h10);
    wr(3'h1, 8'h98);
    cyc(2);
    `CHK(timer_out_pin, 1'b1)
    wr(3'h1, 8'hd8);
    cyc(2);
    `CHK(timer_out_pin, 1'b0)
    close_out;
  end
endmodule // ctc_core_tb
bind ctc_core ctc_core_asserts ctc_core_asserts_inst (.ref_clk(ref_clk), .srst(srst),
  .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_out_pin(timer_out_pin),
  .irq_a_flag(irq_a_flag), .irq_p_flag(irq_p_flag));
